// [pkg/panel_pkg.sv]
// shared constants and types for the operator panel fault and clear-key logic
package panel_pkg;
  // register port geometry
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int NFAULT = 16;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FAULT = 8'h04;
  localparam logic [7:0] OFF_RUNOK = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_SWITCH = 8'h10;
  localparam logic [7:0] OFF_FMT_A = 8'h14;
  localparam logic [7:0] OFF_FMT_B = 8'h18;
  localparam logic [7:0] OFF_INT_STAT = 8'h1c;
  localparam logic [7:0] OFF_INT_MASK = 8'h20;
  localparam logic [7:0] OFF_IO_CODE = 8'h24;

  // control and switch fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ONLINE_BIT = 2;
  localparam int SW_CLEAR_BIT = 0;
  localparam int SW_RUN_BIT = 1;
  localparam int SW_TSEQ_LSB = 4;

  // format fields
  localparam int FA_CPI_LSB = 0;
  localparam int FA_LPI_LSB = 4;
  localparam int FA_FONT_LSB = 8;
  localparam int FA_WID_LSB = 16;
  localparam int FA_HGT_LSB = 20;
  localparam int FB_FLEN_LSB = 0;
  localparam int FB_BOF_LSB = 8;
  localparam int FB_PMOT_BIT = 16;
  localparam int FB_ESC_BIT = 17;

  // power-up format values
  localparam logic [3:0] CPI_RST = 4'h0;
  localparam logic [3:0] LPI_RST = 4'h0;
  localparam logic [7:0] FONT_RST = 8'h00;
  localparam logic [3:0] WID_RST = 4'h1;
  localparam logic [3:0] HGT_RST = 4'h1;
  localparam logic [7:0] FLEN_RST = 8'h42;
  localparam logic [7:0] BOF_RST = 8'h00;
  localparam logic PMOT_RST = 1'b1;
  localparam logic ESC_RST = 1'b1;

  // fault source carrying the i/o board self-test result
  localparam int IO_FAULT_BIT = 0;

  // interrupt status bits
  localparam int NIRQ = 4;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_CLEAR = 1;
  localparam int IRQ_FLUSH = 2;
  localparam int IRQ_RUN = 3;

  // alarm timing
  localparam int CLK_MHZ = 10;
  localparam int ALARM_US = 250000;
  localparam int ALARM_CYC = ALARM_US * CLK_MHZ;

  typedef enum logic [1:0] {
    REGULAR_PRINT_MODE = 2'b00,
    ATTENDANT_SETUP_MODE = 2'b01,
    TEST_MODE = 2'b10
  } mode_t;

  typedef enum logic [2:0] {
    MSG_STATUS = 3'b000,
    MSG_FAULT = 3'b001,
    MSG_IO_SELFTEST_FAULT_CODE = 3'b010,
    MSG_STOP = 3'b011,
    MSG_BUFFER_FLUSHED_NOTICE = 3'b100
  } msg_t;
endpackage : panel_pkg

// [src/key_sync.sv]
// three-stage synchroniser with agreement filter for panel keys
`timescale 1ns/10ps
module key_sync #(
  parameter int W = 2 // number of key pins
) (
  input logic clk, // system clock
  input logic rst, // async reset, active high
  input logic [W-1:0] pin, // raw key levels, high while pressed
  output logic [W-1:0] lvl, // filtered key level
  output logic [W-1:0] rise // one-cycle press pulse
);
  logic [W-1:0] s1_r, s2_r, s3_r, lvl_r, rise_r;

  // s1 only feeds s2; the filter looks at s2 and s3
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lvl_r <= '0;
      rise_r <= '0;
    end else begin
      lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
      rise_r <= (s2_r & s3_r) & ~lvl_r;
    end
  end

  assign lvl = lvl_r;
  assign rise = rise_r;
endmodule : key_sync

// [src/panel_fault_clear.sv]
// operator panel fault handling and clear-key interpreter
`timescale 1ns/10ps
// Summary of operation
// - fault sounds alarm, halts, shows scrolling message
// - run key held may finish form
// - fault clear press drops code, shows stop
// - clear held shows remaining uncorrected faults
// - setup or test clear returns offline, stop
// - regular mode clear discards print buffer
// - flush shows notice and sounds alarm
// - flush restores cpi, lpi, font, width, height
// - flush keeps form length, skip, checks
// - switch state readable through mailbox
// - processor writes status, panel displays it
// - alarm drive output for faults, flushes
// - test fault: clear, exit, then reset
// - self-test fault shows fixed clearable code
module panel_fault_clear #(
  parameter int NF = panel_pkg::NFAULT, // number of fault sources
  parameter int ALARM_CYC = panel_pkg::ALARM_CYC // alarm length in clocks
) (
  input logic clk, // 10 MHz system clock
  input logic rst, // async reset, active high
  input logic [panel_pkg::AW-1:0] addr, // mailbox byte address
  input logic [panel_pkg::DW-1:0] wdata, // mailbox write data
  input logic wr, // write strobe
  input logic rd, // read strobe
  output logic [panel_pkg::DW-1:0] rdata, // read data, cycle after rd
  input logic clear_key_pin, // clear key, high while pressed
  input logic run_key_pin, // run key, high while pressed
  output logic [2:0] disp_msg, // display message selector
  output logic [7:0] disp_arg, // message argument
  output logic disp_scroll, // message scrolls
  output logic alarm, // audible alarm drive
  output logic print_run, // printing allowed
  output logic print_halt, // printing stopped by fault
  output logic flush_buf, // pulse: discard print buffer
  output logic printer_reset, // pulse: reset printer
  output logic irq // level interrupt
);
  localparam int FW = $clog2(NF);

  // lowest pending fault is the one on show and the one cleared
  function automatic logic [FW-1:0] lowest(input logic [NF-1:0] v);
    lowest = '0;
    for (int i = NF - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest = FW'(i);
      end
    end
  endfunction : lowest

  logic [1:0] key_lvl, key_rise;
  logic clear_lvl, run_lvl, clear_p, run_p;
  panel_pkg::mode_t mode_r;
  logic online_r, stop_r, flushed_r;
  logic [1:0] tseq_r;
  logic [NF-1:0] pend_r, runok_r, fault_set, fault_clr;
  logic [panel_pkg::DW-1:0] status_r;
  logic [7:0] io_code_r;
  logic [3:0] cpi_r, lpi_r, wid_r, hgt_r;
  logic [7:0] font_r, flen_r, bof_r;
  logic pmot_r, esc_r;
  logic [panel_pkg::NIRQ-1:0] ist_r, imask_r, ev;
  logic [31:0] alarm_cnt_r;
  logic alarm_r, run_r, halt_r, flush_r, reset_r;
  logic [2:0] msg_r;
  logic [7:0] arg_r;
  logic scroll_r;
  logic [panel_pkg::DW-1:0] rdata_r;
  logic any_fault, fault_new, clr_fault, clr_exit, clr_reset, clr_flush;
  logic wr_ctrl, wr_fault, wr_runok, wr_status, wr_fa, wr_fb, wr_ist, wr_imask, wr_io;
  logic [FW-1:0] cur;

  key_sync #(.W(2)) u_keys (
    .clk(clk),
    .rst(rst),
    .pin({run_key_pin, clear_key_pin}),
    .lvl(key_lvl),
    .rise(key_rise)
  );
  assign clear_lvl = key_lvl[0];
  assign run_lvl = key_lvl[1];
  assign clear_p = key_rise[0];
  assign run_p = key_rise[1];

  // write decode
  assign wr_ctrl = wr && (addr == panel_pkg::OFF_CTRL);
  assign wr_fault = wr && (addr == panel_pkg::OFF_FAULT);
  assign wr_runok = wr && (addr == panel_pkg::OFF_RUNOK);
  assign wr_status = wr && (addr == panel_pkg::OFF_STATUS);
  assign wr_fa = wr && (addr == panel_pkg::OFF_FMT_A);
  assign wr_fb = wr && (addr == panel_pkg::OFF_FMT_B);
  assign wr_ist = wr && (addr == panel_pkg::OFF_INT_STAT);
  assign wr_imask = wr && (addr == panel_pkg::OFF_INT_MASK);
  assign wr_io = wr && (addr == panel_pkg::OFF_IO_CODE);

  // clear key classification; a pending fault takes precedence
  assign any_fault = |pend_r;
  assign cur = lowest(pend_r);
  assign clr_fault = clear_p && any_fault;
  assign clr_exit = clear_p && !any_fault && (mode_r != panel_pkg::REGULAR_PRINT_MODE);
  assign clr_reset = clear_p && !any_fault && (mode_r == panel_pkg::REGULAR_PRINT_MODE) && (tseq_r == 2'h2);
  assign clr_flush = clear_p && !any_fault && (mode_r == panel_pkg::REGULAR_PRINT_MODE) && (tseq_r != 2'h2);

  // fault set by the processor, cleared one at a time by the key
  assign fault_set = wr_fault ? wdata[NF-1:0] : '0;
  assign fault_clr = clr_fault ? (NF'(1) << cur) : '0;
  assign fault_new = |(fault_set & ~pend_r);

  // pending faults; a new report wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~fault_clr) | fault_set;
    end
  end

  // mode and on-line flag; the operator key wins over a software write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= panel_pkg::REGULAR_PRINT_MODE;
      online_r <= 1'b0;
    end else if (clr_exit) begin
      mode_r <= panel_pkg::REGULAR_PRINT_MODE;
      online_r <= 1'b0;
    end else if (clr_fault) begin
      online_r <= 1'b0;
    end else if (wr_ctrl) begin
      if (wdata[panel_pkg::CTRL_MODE_LSB +: 2] == 2'h3) begin
        mode_r <= panel_pkg::REGULAR_PRINT_MODE;
      end else begin
        mode_r <= panel_pkg::mode_t'(wdata[panel_pkg::CTRL_MODE_LSB +: 2]);
      end
      online_r <= wdata[panel_pkg::CTRL_ONLINE_BIT];
    end
  end

  // three-press sequence after a fault raised in test mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tseq_r <= 2'h0;
    end else if (clr_fault) begin
      tseq_r <= (mode_r == panel_pkg::TEST_MODE) ? 2'h1 : 2'h0;
    end else if (clr_exit) begin
      tseq_r <= ((mode_r == panel_pkg::TEST_MODE) && (tseq_r == 2'h1)) ? 2'h2 : 2'h0;
    end else if (clr_reset || clr_flush) begin
      tseq_r <= 2'h0;
    end
  end

  // stop and flushed indications; setting wins over clearing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stop_r <= 1'b0;
      flushed_r <= 1'b0;
    end else begin
      if (clr_fault || clr_exit) begin
        stop_r <= 1'b1;
      end else if (fault_new || wr_ctrl || clr_flush) begin
        stop_r <= 1'b0;
      end
      if (clr_flush) begin
        flushed_r <= 1'b1;
      end else if (fault_new || wr_ctrl || clear_p) begin
        flushed_r <= 1'b0;
      end
    end
  end

  // format settings; a flush restores only the character shape group
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpi_r <= panel_pkg::CPI_RST;
      lpi_r <= panel_pkg::LPI_RST;
      font_r <= panel_pkg::FONT_RST;
      wid_r <= panel_pkg::WID_RST;
      hgt_r <= panel_pkg::HGT_RST;
    end else if (clr_flush || clr_reset) begin
      cpi_r <= panel_pkg::CPI_RST;
      lpi_r <= panel_pkg::LPI_RST;
      font_r <= panel_pkg::FONT_RST;
      wid_r <= panel_pkg::WID_RST;
      hgt_r <= panel_pkg::HGT_RST;
    end else if (wr_fa) begin
      cpi_r <= wdata[panel_pkg::FA_CPI_LSB +: 4];
      lpi_r <= wdata[panel_pkg::FA_LPI_LSB +: 4];
      font_r <= wdata[panel_pkg::FA_FONT_LSB +: 8];
      wid_r <= wdata[panel_pkg::FA_WID_LSB +: 4];
      hgt_r <= wdata[panel_pkg::FA_HGT_LSB +: 4];
    end
  end

  // form settings change only by software, never by the clear key
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flen_r <= panel_pkg::FLEN_RST;
      bof_r <= panel_pkg::BOF_RST;
      pmot_r <= panel_pkg::PMOT_RST;
      esc_r <= panel_pkg::ESC_RST;
    end else if (wr_fb) begin
      flen_r <= wdata[panel_pkg::FB_FLEN_LSB +: 8];
      bof_r <= wdata[panel_pkg::FB_BOF_LSB +: 8];
      pmot_r <= wdata[panel_pkg::FB_PMOT_BIT];
      esc_r <= wdata[panel_pkg::FB_ESC_BIT];
    end
  end

  // mailbox words written by the processors
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_r <= '0;
      runok_r <= '0;
      io_code_r <= 8'h00;
      imask_r <= '0;
    end else begin
      if (wr_status) begin
        status_r <= wdata;
      end
      if (wr_runok) begin
        runok_r <= wdata[NF-1:0];
      end
      if (wr_io) begin
        io_code_r <= wdata[7:0];
      end
      if (wr_imask) begin
        imask_r <= wdata[panel_pkg::NIRQ-1:0];
      end
    end
  end

  // sticky interrupt status, write one to clear, new event wins
  always_comb begin
    ev = '0;
    ev[panel_pkg::IRQ_FAULT] = fault_new;
    ev[panel_pkg::IRQ_CLEAR] = clear_p;
    ev[panel_pkg::IRQ_FLUSH] = clr_flush;
    ev[panel_pkg::IRQ_RUN] = run_p;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ist_r <= '0;
    end else begin
      ist_r <= (ist_r & ~(wr_ist ? wdata[panel_pkg::NIRQ-1:0] : '0)) | ev;
    end
  end
  assign irq = |(ist_r & imask_r);

  // alarm timer, restarted by each new fault or flush
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm_cnt_r <= 32'h0;
      alarm_r <= 1'b0;
    end else if (fault_new || clr_flush) begin
      alarm_cnt_r <= 32'(ALARM_CYC - 1);
      alarm_r <= 1'b1;
    end else if (alarm_cnt_r != 32'h0) begin
      alarm_cnt_r <= alarm_cnt_r - 32'h1;
    end else begin
      alarm_r <= 1'b0;
    end
  end

  // print permission; run key only helps if every pending fault allows it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_r <= 1'b0;
      halt_r <= 1'b0;
      flush_r <= 1'b0;
      reset_r <= 1'b0;
    end else begin
      halt_r <= any_fault;
      run_r <= (!any_fault && online_r && (mode_r == panel_pkg::REGULAR_PRINT_MODE))
        || (any_fault && run_lvl && ((pend_r & ~runok_r) == '0));
      flush_r <= clr_flush;
      reset_r <= clr_reset;
    end
  end

  // display selection; held clear key reveals faults behind the stop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      msg_r <= panel_pkg::MSG_STATUS;
      arg_r <= 8'h00;
      scroll_r <= 1'b0;
    end else if (any_fault && (clear_lvl || !stop_r)) begin
      if (cur == FW'(panel_pkg::IO_FAULT_BIT)) begin
        msg_r <= panel_pkg::MSG_IO_SELFTEST_FAULT_CODE;
        arg_r <= io_code_r;
        scroll_r <= 1'b0;
      end else begin
        msg_r <= panel_pkg::MSG_FAULT;
        arg_r <= 8'(cur);
        scroll_r <= 1'b1;
      end
    end else if (stop_r) begin
      msg_r <= panel_pkg::MSG_STOP;
      arg_r <= 8'h00;
      scroll_r <= 1'b0;
    end else if (flushed_r) begin
      msg_r <= panel_pkg::MSG_BUFFER_FLUSHED_NOTICE;
      arg_r <= 8'h00;
      scroll_r <= 1'b0;
    end else begin
      msg_r <= panel_pkg::MSG_STATUS;
      arg_r <= status_r[7:0];
      scroll_r <= 1'b0;
    end
  end

  // read mux; unmapped addresses read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (!rd) begin
      rdata_r <= '0;
    end else if (addr == panel_pkg::OFF_CTRL) begin
      rdata_r <= 32'({online_r, mode_r});
    end else if (addr == panel_pkg::OFF_FAULT) begin
      rdata_r <= 32'(pend_r);
    end else if (addr == panel_pkg::OFF_RUNOK) begin
      rdata_r <= 32'(runok_r);
    end else if (addr == panel_pkg::OFF_STATUS) begin
      rdata_r <= status_r;
    end else if (addr == panel_pkg::OFF_SWITCH) begin
      rdata_r <= 32'({tseq_r, 2'h0, run_lvl, clear_lvl});
    end else if (addr == panel_pkg::OFF_FMT_A) begin
      rdata_r <= 32'({hgt_r, wid_r, font_r, lpi_r, cpi_r});
    end else if (addr == panel_pkg::OFF_FMT_B) begin
      rdata_r <= 32'({esc_r, pmot_r, bof_r, flen_r});
    end else if (addr == panel_pkg::OFF_INT_STAT) begin
      rdata_r <= 32'(ist_r);
    end else if (addr == panel_pkg::OFF_INT_MASK) begin
      rdata_r <= 32'(imask_r);
    end else if (addr == panel_pkg::OFF_IO_CODE) begin
      rdata_r <= 32'(io_code_r);
    end else begin
      rdata_r <= '0;
    end
  end

  assign rdata = rdata_r;
  assign disp_msg = msg_r;
  assign disp_arg = arg_r;
  assign disp_scroll = scroll_r;
  assign alarm = alarm_r;
  assign print_run = run_r;
  assign print_halt = halt_r;
  assign flush_buf = flush_r;
  assign printer_reset = reset_r;

  // checks on the clear-key interpreter
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_last_clear;
    clear_p && $onehot(pend_r) && !wr_fault ##1 !wr_fault;
  endsequence

  sequence s_regular_idle_clear;
    clear_p && !any_fault && (mode_r == panel_pkg::REGULAR_PRINT_MODE) && (tseq_r != 2'h2);
  endsequence

  a_fault_halts: assert property ((wr_fault && (wdata[NF-1:0] != '0)) |=> ##1 halt_r)
    else $error("fault report did not halt printing");
  a_fault_alarm: assert property (fault_new |=> alarm_r [*2])
    else $error("new fault did not sound the alarm");
  a_run_gate: assert property ((any_fault && !run_lvl) |=> !run_r)
    else $error("printing allowed with fault and run key up");
  a_stop_shown: assert property (s_last_clear |=> msg_r == panel_pkg::MSG_STOP)
    else $error("stop not shown after last fault cleared");
  a_held_others: assert property ((clear_lvl && any_fault && !pend_r[panel_pkg::IO_FAULT_BIT])
    |=> (msg_r == panel_pkg::MSG_FAULT) && scroll_r)
    else $error("remaining fault not shown while clear held");
  a_mode_exit: assert property ((clear_p && !any_fault && (mode_r != panel_pkg::REGULAR_PRINT_MODE))
    |=> (mode_r == panel_pkg::REGULAR_PRINT_MODE) && !online_r && stop_r)
    else $error("clear in setup or test mode did not go offline");
  a_flush_pulse: assert property (s_regular_idle_clear |=> flush_r ##1 !flush_r)
    else $error("flush pulse missing or too long");
  a_flush_notice: assert property ((!wr_fault ##0 s_regular_idle_clear) ##1 !wr_fault && !wr_ctrl && !clear_p
    |=> (msg_r == panel_pkg::MSG_BUFFER_FLUSHED_NOTICE) && alarm_r)
    else $error("flush notice or alarm missing");
  a_fmt_restore: assert property (s_regular_idle_clear |=> (cpi_r == panel_pkg::CPI_RST)
    && (font_r == panel_pkg::FONT_RST) && (hgt_r == panel_pkg::HGT_RST))
    else $error("format settings not restored");
  a_form_kept: assert property ((clear_p && !wr_fb) |=> $stable(flen_r) && $stable(esc_r))
    else $error("form settings changed by clear key");
  a_test_third: assert property ((clear_p && !any_fault && (tseq_r == 2'h2)
    && (mode_r == panel_pkg::REGULAR_PRINT_MODE)) |=> reset_r && !flush_r)
    else $error("third clear did not reset the printer");
  a_io_fixed: assert property ((msg_r == panel_pkg::MSG_IO_SELFTEST_FAULT_CODE) |-> !scroll_r)
    else $error("self-test code scrolls");
  a_fault_first: assert property ((clear_p && any_fault && !wr_ctrl)
    |=> !flush_r && !reset_r && $stable(mode_r))
    else $error("clear with pending fault took a mode action");
  a_switch_read: assert property ((rd && (addr == panel_pkg::OFF_SWITCH))
    |=> rdata_r[panel_pkg::SW_CLEAR_BIT] == $past(clear_lvl))
    else $error("switch state read wrong");
endmodule : panel_fault_clear

// [dv/panel_keys.sv]
// front panel key model driving the clear and run key pins
`timescale 1ns/10ps
module panel_keys (
  input logic clk, // system clock
  output logic clear_key_pin, // clear key, high while pressed
  output logic run_key_pin // run key, high while pressed
);
  // keys start released
  initial begin
    clear_key_pin = 1'b0;
    run_key_pin = 1'b0;
  end

  // change one key level, then wait out sync, filter and display update
  task automatic set_key(input bit run, input bit lvl);
    @(posedge clk);
    if (run) begin
      run_key_pin <= lvl;
    end else begin
      clear_key_pin <= lvl;
    end
    repeat (7) @(posedge clk);
    #1;
  endtask : set_key
endmodule : panel_keys

// [dv/test_panel_fault_clear.sv]
// self-checking bench for the panel fault and clear-key interpreter
`timescale 1ns/10ps
module test_panel_fault_clear;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [panel_pkg::AW-1:0] addr = 8'h00;
  logic [panel_pkg::DW-1:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [panel_pkg::DW-1:0] rdata;
  logic clear_key_pin, run_key_pin, disp_scroll, alarm, print_run, print_halt, flush_buf, printer_reset, irq;
  logic [2:0] disp_msg;
  logic [7:0] disp_arg;
  logic [31:0] v, fb;
  int num_errors = 0;
  int checks_done = 0;
  int n_flush = 0;
  int n_reset = 0;
  int a, b, f0;

  // 10 MHz clock
  always #50 clk = ~clk;

  panel_keys keys_u (.clk(clk), .clear_key_pin(clear_key_pin), .run_key_pin(run_key_pin));

  panel_fault_clear #(.ALARM_CYC(8)) dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .clear_key_pin(clear_key_pin), .run_key_pin(run_key_pin), .disp_msg(disp_msg),
    .disp_arg(disp_arg), .disp_scroll(disp_scroll), .alarm(alarm), .print_run(print_run),
    .print_halt(print_halt), .flush_buf(flush_buf), .printer_reset(printer_reset), .irq(irq));

  // count one-cycle action pulses so missing or doubled ones show
  always @(posedge clk) begin
    if (flush_buf === 1'b1) n_flush++;
    if (printer_reset === 1'b1) n_reset++;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // power-up image of the first format register
  function automatic logic [31:0] fmt_a_pwr();
    return {8'h00, panel_pkg::HGT_RST, panel_pkg::WID_RST, panel_pkg::FONT_RST, panel_pkg::LPI_RST,
      panel_pkg::CPI_RST};
  endfunction : fmt_a_pwr

  task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [7:0] ad, input logic [31:0] exp);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(what, rdata, exp);
  endtask : rd_chk

  task automatic disp_chk(input logic [2:0] m, input logic [7:0] ag, input logic s);
    check("display", {20'h0, disp_scroll, disp_msg, disp_arg}, {20'h0, s, m, ag});
  endtask : disp_chk

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic press_clear();
    keys_u.set_key(1'b0, 1'b1);
    keys_u.set_key(1'b0, 1'b0);
  endtask : press_clear

  task automatic conclude();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    conclude();
  end

  initial begin
    void'($urandom(60));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    disp_chk(panel_pkg::MSG_STATUS, 8'h00, 1'b0);
    rd_chk("fmt_a", panel_pkg::OFF_FMT_A, fmt_a_pwr());
    rd_chk("unmapped", 8'h28, 32'h0);
    v = $urandom;
    wr_reg(panel_pkg::OFF_STATUS, v);
    settle();
    disp_chk(panel_pkg::MSG_STATUS, v[7:0], 1'b0);
    // two faults, cleared one press at a time
    a = 1 + $urandom % 14;
    b = a + 1 + $urandom % (15 - a);
    wr_reg(panel_pkg::OFF_INT_MASK, 32'h1);
    wr_reg(panel_pkg::OFF_FAULT, (32'h1 << a) | (32'h1 << b));
    settle();
    check("halt alarm", {print_halt, alarm, print_run}, 3'b110);
    disp_chk(panel_pkg::MSG_FAULT, 8'(a), 1'b1);
    check("irq", irq, 1'b1);
    f0 = n_flush;
    keys_u.set_key(1'b0, 1'b1);
    disp_chk(panel_pkg::MSG_FAULT, 8'(b), 1'b1);
    rd_chk("fault left", panel_pkg::OFF_FAULT, 32'h1 << b);
    keys_u.set_key(1'b0, 1'b0);
    check("stop", disp_msg, panel_pkg::MSG_STOP);
    press_clear();
    rd_chk("fault gone", panel_pkg::OFF_FAULT, 32'h0);
    check("no flush", n_flush, f0);
    wr_reg(panel_pkg::OFF_INT_STAT, 32'hf);
    settle();
    check("irq off", irq, 1'b0);
    check("alarm off", alarm, 1'b0);
    // run key finishes the form only for faults allowed to run
    wr_reg(panel_pkg::OFF_RUNOK, 32'h1 << a);
    wr_reg(panel_pkg::OFF_FAULT, 32'h1 << a);
    keys_u.set_key(1'b1, 1'b1);
    check("run ok", print_run, 1'b1);
    wr_reg(panel_pkg::OFF_FAULT, 32'h1 << b);
    settle();
    check("run blocked", print_run, 1'b0);
    keys_u.set_key(1'b1, 1'b0);
    press_clear();
    press_clear();
    // setup and test mode both drop back to offline regular
    for (int m = 1; m <= 2; m++) begin
      wr_reg(panel_pkg::OFF_CTRL, 32'(m) | 32'h4);
      press_clear();
      rd_chk("mode exit", panel_pkg::OFF_CTRL, 32'h0);
      check("stop", disp_msg, panel_pkg::MSG_STOP);
    end
    // mode code 3 falls back to regular; on-line regular with no fault prints
    wr_reg(panel_pkg::OFF_CTRL, 32'h7);
    rd_chk("mode 3", panel_pkg::OFF_CTRL, 32'h4);
    check("run online", print_run, 1'b1);
    // fault in test mode: clear, exit, reset
    f0 = n_flush;
    wr_reg(panel_pkg::OFF_CTRL, 32'h2);
    wr_reg(panel_pkg::OFF_FAULT, 32'h8);
    press_clear();
    rd_chk("test kept", panel_pkg::OFF_CTRL, 32'h2);
    press_clear();
    rd_chk("test left", panel_pkg::OFF_CTRL, 32'h0);
    press_clear();
    check("reset pulse", n_reset, 32'd1);
    check("no flush on reset", n_flush, f0);
    // self-test fault shows fixed code and can be cleared
    v = $urandom;
    wr_reg(panel_pkg::OFF_IO_CODE, v);
    wr_reg(panel_pkg::OFF_FAULT, 32'h1 << panel_pkg::IO_FAULT_BIT);
    settle();
    disp_chk(panel_pkg::MSG_IO_SELFTEST_FAULT_CODE, v[7:0], 1'b0);
    press_clear();
    rd_chk("io cleared", panel_pkg::OFF_FAULT, 32'h0);
    // regular mode flush resets only part of the format
    fb = $urandom;
    wr_reg(panel_pkg::OFF_FMT_A, $urandom);
    wr_reg(panel_pkg::OFF_FMT_B, fb);
    f0 = n_flush;
    keys_u.set_key(1'b0, 1'b1);
    check("flush", n_flush, f0 + 1);
    check("notice alarm", {alarm, disp_msg}, {1'b1, panel_pkg::MSG_BUFFER_FLUSHED_NOTICE});
    rd_chk("switch", panel_pkg::OFF_SWITCH, 32'h1);
    keys_u.set_key(1'b0, 1'b0);
    rd_chk("fmt_a", panel_pkg::OFF_FMT_A, fmt_a_pwr());
    rd_chk("fmt_b", panel_pkg::OFF_FMT_B, fb & 32'h3ffff);
    conclude();
  end
endmodule : test_panel_fault_clear
